// [verification/low_power_oneshot_timer_bench.sv]
// Self-checking testbench for the low-power one-shot timer.
`timescale 1ns/1ps
module low_power_oneshot_timer_bench;
   // ****************************************************
   // Signals.
   // ****************************************************
   localparam int OSC_DIV  = 8;
   localparam int TICK_CYC = lpt_pkg::TICKS_PER_MS * OSC_DIV;
   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [11:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        osc_20k;
   logic        irq_n;
   logic [2:0]  osc_cnt_ff;
   int          err_count;
   int          n_compared;

   lpt_timer lpt_timer_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .osc_20k(osc_20k), .irq_n(irq_n)
   );

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // The oscillator runs far faster than 20 kHz so that one step costs 160 cycles
   // instead of 40000; the timer only counts its rising edges, 20 to a step.
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt_ff <= 3'h0;
         osc_20k    <= 1'b0;
      end else begin
         osc_cnt_ff <= osc_cnt_ff + 3'h1;
         osc_20k    <= osc_cnt_ff[2];
      end
   end

   // ****************************************************
   // Shared tasks.
   // ****************************************************
   task automatic stop_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic axi_write(input logic [9:0] idx, input logic [31:0] data,
                            input logic [1:0] resp = lpt_pkg::RESP_OKAY);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= data;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 100 && !done; n++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            done = 1'b1;
            check("bresp", 32'(bresp), 32'(resp));
         end
      end
      if (!done) begin
         check("write answer", 32'h0000_0000, 32'h0000_0001);
      end
   endtask : axi_write

   task automatic axi_read(input string name, input logic [9:0] idx, input logic [31:0] exp,
                           input logic [1:0] resp = lpt_pkg::RESP_OKAY);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 100 && !done; n++) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            done = 1'b1;
            check(name, rdata, exp);
            check("rresp", 32'(rresp), 32'(resp));
         end
      end
      if (!done) begin
         check("read answer", 32'h0000_0000, 32'h0000_0001);
      end
   endtask : axi_read

   // ****************************************************
   // Scenarios.
   // ****************************************************
   task automatic test_reset_values();
      check("irq_n", 32'(irq_n), 32'h0000_0001);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0000);
      axi_read("reload", lpt_pkg::IDX_RELOAD, 32'(lpt_pkg::RELOAD_RESET));
      axi_read("count", lpt_pkg::IDX_COUNT, 32'(lpt_pkg::COUNT_RESET));
      axi_read("control", lpt_pkg::IDX_CTL, 32'h0000_0000);
      axi_read("hole", 10'h0A6, 32'h0000_0000, lpt_pkg::RESP_SLVERR);
      axi_write(10'h0A6, 32'h0000_FFFF, lpt_pkg::RESP_SLVERR);
   endtask : test_reset_values

   task automatic test_count_halt_resume();
      axi_write(lpt_pkg::IDX_INT_EN, 32'h0000_0001);
      axi_write(lpt_pkg::IDX_RELOAD, 32'h0000_0002);
      axi_write(lpt_pkg::IDX_CTL, 32'h0000_0003);
      repeat (TICK_CYC / 2) @(posedge aclk);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_0002);
      repeat (TICK_CYC) @(posedge aclk);
      axi_write(lpt_pkg::IDX_CTL, 32'h0000_0000);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_0001);
      repeat (2 * TICK_CYC) @(posedge aclk);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_0001);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0000);
      axi_write(lpt_pkg::IDX_CTL, 32'h0000_0001);
      repeat (3 * TICK_CYC) @(posedge aclk);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_FFFF);
      axi_read("source", lpt_pkg::IDX_INT_SRC, 32'h0000_0001);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0001);
      check("irq_n", 32'(irq_n), 32'h0000_0000);
      repeat (2 * TICK_CYC) @(posedge aclk);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_FFFF);
   endtask : test_count_halt_resume

   task automatic test_irq_mask_clear();
      axi_write(lpt_pkg::IDX_INT_EN, 32'h0000_0000);
      repeat (4) @(posedge aclk);
      check("irq_n", 32'(irq_n), 32'h0000_0001);
      axi_write(lpt_pkg::IDX_INT_EN, 32'h0000_0001);
      repeat (4) @(posedge aclk);
      check("irq_n", 32'(irq_n), 32'h0000_0000);
      axi_write(lpt_pkg::IDX_INT_SRC, 32'h0000_0000);
      axi_read("source", lpt_pkg::IDX_INT_SRC, 32'h0000_0001);
      axi_write(lpt_pkg::IDX_INT_SRC, 32'h0000_0001);
      axi_read("source", lpt_pkg::IDX_INT_SRC, 32'h0000_0000);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0000);
      repeat (4) @(posedge aclk);
      check("irq_n", 32'(irq_n), 32'h0000_0001);
   endtask : test_irq_mask_clear

   task automatic test_auto_disable_burst();
      axi_write(lpt_pkg::IDX_RELOAD, 32'h0000_0001);
      axi_write(lpt_pkg::IDX_INT_SRC, 32'h0000_0001);
      axi_write(lpt_pkg::IDX_CTL, 32'h0000_0007);
      repeat (TICK_CYC / 2) @(posedge aclk);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_0001);
      repeat (3 * TICK_CYC) @(posedge aclk);
      axi_read("control", lpt_pkg::IDX_CTL, 32'h0000_0004);
      axi_read("count", lpt_pkg::IDX_COUNT, 32'h0000_FFFF);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0001);
      check("irq_n", 32'(irq_n), 32'h0000_0000);
      axi_write(lpt_pkg::IDX_INT_CLR, 32'h0000_0001);
      axi_read("status", lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS, 32'h0000_0000);
      repeat (4) @(posedge aclk);
      check("irq_n", 32'(irq_n), 32'h0000_0001);
   endtask : test_auto_disable_burst

   // ****************************************************
   // Main sequence and watchdog.
   // ****************************************************
   initial begin
      aresetn    = 1'b0;
      awaddr     = 12'h000;
      awvalid    = 1'b0;
      wdata      = 32'h0000_0000;
      wvalid     = 1'b0;
      bready     = 1'b0;
      araddr     = 12'h000;
      arvalid    = 1'b0;
      rready     = 1'b0;
      err_count  = 0;
      n_compared = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset_values();
      test_count_halt_resume();
      test_irq_mask_clear();
      test_auto_disable_burst();
      stop_test();
   end

   // The scenarios need about 2100 cycles; the margin covers a slow bus answer.
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      stop_test();
   end
endmodule : low_power_oneshot_timer_bench

// [verilog/lpt_pkg.sv]
// Package of constants for the low-power one-shot timer.
package lpt_pkg;
   // ****************************************************
   // Register indices; byte address is four times the index.
   // ****************************************************
   localparam logic [9:0] IDX_SYSTEM_INTERRUPT_STATUS  = 10'h010;
   localparam logic [9:0] IDX_INT_CLR  = 10'h011;
   localparam logic [9:0] IDX_INT_EN   = 10'h014;
   localparam logic [9:0] IDX_RELOAD   = 10'h0A0;
   localparam logic [9:0] IDX_INT_SRC  = 10'h0A2;
   localparam logic [9:0] IDX_CTL      = 10'h0A3;
   localparam logic [9:0] IDX_COUNT    = 10'h0A4;
   // ****************************************************
   // Field positions and reset values.
   // ****************************************************
   localparam int          CTL_ENABLE_BIT = 0;
   localparam int          CTL_RELOAD_BIT = 1;
   localparam int          CTL_AUTO_BIT   = 2;
   localparam int          UFLOW_BIT      = 0;
   localparam int          SUMMARY_BIT    = 0;
   localparam logic [15:0] RELOAD_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // ****************************************************
   // Timing.
   // ****************************************************
   localparam int OSC_HZ       = 20000;
   localparam int TICK_MS      = 1;
   localparam int TICKS_PER_MS = OSC_HZ * TICK_MS / 1000;
endpackage : lpt_pkg

// [verilog/lpt_timer.sv]
// Low-power one-shot timer with an AXI4-Lite register slave.
`timescale 1ns/1ps
module lpt_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              osc_20k,
   output logic                   irq_n
);
   localparam logic [4:0] PRE_LAST = 5'(lpt_pkg::TICKS_PER_MS - 1);

   // ****************************************************
   // Oscillator crossing.
   // ****************************************************
   // The oscillator is slow against aclk, so each rising edge is seen once.
   logic [2:0] osc_sync_ff;
   logic       osc_lvl_ff;
   logic       osc_rise;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_sync_ff <= 3'h0;
         osc_lvl_ff  <= 1'b0;
      end else begin
         osc_sync_ff <= {osc_sync_ff[1:0], osc_20k};
         if (osc_sync_ff[1] == osc_sync_ff[2]) begin
            osc_lvl_ff <= osc_sync_ff[2];
         end
      end
   end
   assign osc_rise = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_lvl_ff;

   // ****************************************************
   // Write channel.
   // ****************************************************
   logic              aw_got_ff;
   logic              w_got_ff;
   logic [9:0]        wr_idx_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              do_wr;
   logic              wr_map;
   logic [15:0]       wr_mask;
   assign s_axi_awready = !aw_got_ff;
   assign s_axi_wready  = !w_got_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wr_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign wr_map  = wr_idx_ff inside {lpt_pkg::IDX_INT_CLR, lpt_pkg::IDX_INT_EN,
                    lpt_pkg::IDX_RELOAD, lpt_pkg::IDX_INT_SRC, lpt_pkg::IDX_CTL};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         wr_idx_ff <= 10'h000;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= lpt_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_got_ff) begin
            aw_got_ff <= 1'b1;
            wr_idx_ff <= s_axi_awaddr[11:2];
         end else if (do_wr) begin
            aw_got_ff <= 1'b0;
         end
         if (s_axi_wvalid && !w_got_ff) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (do_wr) begin
            w_got_ff <= 1'b0;
         end
         if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_map ? lpt_pkg::RESP_OKAY : lpt_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   logic wr_reload;
   logic wr_ctl;
   logic wr_ien;
   logic flag_clr;
   logic ctl_load;
   assign wr_reload = do_wr && (wr_idx_ff == lpt_pkg::IDX_RELOAD);
   assign wr_ctl    = do_wr && (wr_idx_ff == lpt_pkg::IDX_CTL) && wstrb_ff[0];
   assign wr_ien    = do_wr && (wr_idx_ff == lpt_pkg::IDX_INT_EN) && wstrb_ff[0];
   assign ctl_load  = wr_ctl && wdata_ff[lpt_pkg::CTL_RELOAD_BIT];
   assign flag_clr  = do_wr && wstrb_ff[0] && wdata_ff[lpt_pkg::UFLOW_BIT]
                      && (wr_idx_ff == lpt_pkg::IDX_INT_SRC
                          || wr_idx_ff == lpt_pkg::IDX_INT_CLR);

   // ****************************************************
   // Control registers.
   // ****************************************************
   logic [CNT_W-1:0] reload_ff;
   logic             auto_ff;
   logic             ien_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_ff <= CNT_W'(lpt_pkg::RELOAD_RESET);
      end else if (wr_reload) begin
         reload_ff <= CNT_W'((reload_ff & ~wr_mask) | (wdata_ff[15:0] & wr_mask));
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         auto_ff <= 1'b0;
         ien_ff  <= 1'b0;
      end else begin
         if (wr_ctl) begin
            auto_ff <= wdata_ff[lpt_pkg::CTL_AUTO_BIT];
         end
         if (wr_ien) begin
            ien_ff <= wdata_ff[lpt_pkg::SUMMARY_BIT];
         end
      end
   end

   // ****************************************************
   // Millisecond prescaler and down counter.
   // ****************************************************
   logic             enable_ff;
   logic             halt_ff;
   logic [4:0]       pre_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             run;
   logic             dec;
   logic             uflow;
   assign run   = enable_ff && !halt_ff;
   assign dec   = run && osc_rise && (pre_ff == PRE_LAST);
   assign uflow = dec && (cnt_ff == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_ff <= 5'h00;
      end else if (ctl_load) begin
         pre_ff <= 5'h00;
      end else if (run && osc_rise) begin
         pre_ff <= (pre_ff == PRE_LAST) ? 5'h00 : pre_ff + 5'h01;
      end
   end
   // A halt keeps both count and prescaler, so a resumed run picks up where it stopped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= CNT_W'(lpt_pkg::COUNT_RESET);
      end else if (ctl_load) begin
         cnt_ff <= reload_ff;
      end else if (dec) begin
         cnt_ff <= cnt_ff - CNT_W'(1);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_ff <= 1'b0;
      end else if (ctl_load) begin
         halt_ff <= 1'b0;
      end else if (uflow) begin
         halt_ff <= 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_ff <= 1'b0;
      end else if (wr_ctl) begin
         enable_ff <= wdata_ff[lpt_pkg::CTL_ENABLE_BIT];
      end else if (uflow && auto_ff) begin
         enable_ff <= 1'b0;
      end
   end

   // ****************************************************
   // Underflow flag and interrupt.
   // ****************************************************
   // With auto-disable the flag waits one cycle so enable is already low when it rises.
   logic pend_ff;
   logic flag_ff;
   logic flag_set;
   logic irq_n_ff;
   assign flag_set = (uflow && !auto_ff) || pend_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff  <= 1'b0;
         flag_ff  <= 1'b0;
         irq_n_ff <= 1'b1;
      end else begin
         pend_ff <= uflow && auto_ff;
         if (flag_set) begin
            flag_ff <= 1'b1;
         end else if (flag_clr) begin
            flag_ff <= 1'b0;
         end
         irq_n_ff <= !(flag_ff && ien_ff);
      end
   end
   assign irq_n = irq_n_ff;

   // ****************************************************
   // Read channel.
   // ****************************************************
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [31:0] rd_val;
   logic        rd_map;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_map = 1'b1;
      unique case (s_axi_araddr[11:2])
         lpt_pkg::IDX_SYSTEM_INTERRUPT_STATUS: rd_val[lpt_pkg::SUMMARY_BIT] = flag_ff;
         lpt_pkg::IDX_INT_EN:  rd_val[lpt_pkg::SUMMARY_BIT] = ien_ff;
         lpt_pkg::IDX_INT_CLR: rd_val = 32'h0000_0000;
         lpt_pkg::IDX_RELOAD:  rd_val[CNT_W-1:0] = reload_ff;
         lpt_pkg::IDX_INT_SRC: rd_val[lpt_pkg::UFLOW_BIT] = flag_ff;
         lpt_pkg::IDX_CTL: begin
            rd_val[lpt_pkg::CTL_ENABLE_BIT] = enable_ff;
            rd_val[lpt_pkg::CTL_AUTO_BIT]   = auto_ff;
         end
         lpt_pkg::IDX_COUNT:   rd_val[CNT_W-1:0] = cnt_ff;
         default:              rd_map = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= lpt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_val;
         rresp_ff  <= rd_map ? lpt_pkg::RESP_OKAY : lpt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ****************************************************
   // Checks.
   // ****************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_wrap;
      uflow |=> cnt_ff == '1;
   endproperty
   a_wrap: assert property (p_wrap) else $error("Underflow did not wrap count.");
   property p_stop;
      halt_ff && !ctl_load |=> $stable(cnt_ff);
   endproperty
   a_stop: assert property (p_stop) else $error("Counter moved after underflow.");
   property p_flag;
      uflow |-> ##[1:2] flag_ff;
   endproperty
   a_flag: assert property (p_flag) else $error("Underflow flag not set.");
   property p_pin;
      flag_ff && ien_ff |=> !irq_n;
   endproperty
   a_pin: assert property (p_pin) else $error("Interrupt pin not driven low.");
   property p_quiet;
      !flag_ff |=> irq_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("Interrupt pin low without flag.");
   property p_load;
      ctl_load |=> cnt_ff == $past(reload_ff);
   endproperty
   a_load: assert property (p_load) else $error("Reload value not loaded.");
   property p_hold;
      !enable_ff && !ctl_load |=> $stable(cnt_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("Count changed while disabled.");
   // Counts oscillator edges apart from the prescaler, so a slip in either one shows up.
   logic [4:0] chk_rise_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || ctl_load) begin
         chk_rise_ff <= 5'h00;
      end else if (run && osc_rise) begin
         chk_rise_ff <= dec ? 5'h00 : chk_rise_ff + 5'h01;
      end
   end
   property p_rate;
      run && osc_rise |-> dec == (chk_rise_ff == PRE_LAST);
   endproperty
   a_rate: assert property (p_rate) else $error("Decrement off the millisecond.");
   sequence s_auto_uf;
      uflow && auto_ff && !wr_ctl;
   endsequence
   sequence s_off_then_flag;
      !enable_ff && !flag_ff ##1 flag_ff;
   endsequence
   property p_auto;
      s_auto_uf |=> s_off_then_flag;
   endproperty
   a_auto: assert property (p_auto) else $error("Auto-disable order wrong.");
   property p_w1c;
      flag_ff && !flag_clr && !flag_set |=> flag_ff;
   endproperty
   a_w1c: assert property (p_w1c) else $error("Flag cleared without a one write.");
endmodule : lpt_timer
